// File: logic/dazfc_pkg.sv
// Constants for the attenuation / zero flag control block.
// Assumes a single 20 MHz clock and a register port fed by the serial
// control decoder.
// Behaviour
// R1 - Mode 0: 0.5 dB steps from 0 dB to -63 dB, then mute
// R2 - Mode 1: 1 dB steps from 0 dB to -100 dB, then mute
// R3 - De-emphasis field: 00 off, 01 48k, 10 44.1k, 11 32k
// R4 - Shared pin carries zero flag 2, or analog mute when selected
// R5 - Flags per channel, or left OR right / left AND right
// R6 - Zero flags high on detect, or low when polarity bit set
// R7 - Applied level moves one step every 8 sample periods toward target
// R8 - Attenuation equals step times (level code minus 255)
// R9 - Codes 0..128 mute in fine mode, 0..154 in wide mode
// R10 - Level registers reset to all ones, meaning 0 dB
// R11 - Register 18 sets channel 1, register 19 sets channel 2
// R12 - Soft mute ramps to mute, release ramps back; mute has priority
// R13 - Target change mid-ramp continues from the applied level
`default_nettype none
package dazfc_pkg;
  localparam int          ADDR_W       = 7;
  localparam logic [6:0]  ADDR_CFG     = 7'h16;
  localparam logic [6:0]  ADDR_RSVD    = 7'h17;
  localparam logic [6:0]  ADDR_LVL1    = 7'h18;
  localparam logic [6:0]  ADDR_LVL2    = 7'h19;
  localparam int          BIT_MODE     = 7;
  localparam int          BIT_DEEMPH_RATE_SEL_HI  = 5;
  localparam int          BIT_DEEMPH_RATE_SEL_LO  = 4;
  localparam int          BIT_PINSEL   = 3;
  localparam int          BIT_COMBO    = 1;
  localparam int          BIT_POL      = 0;
  localparam logic [7:0]  CFG_WMASK    = 8'hBB;
  localparam logic [7:0]  CFG_RESET    = 8'h00;
  localparam logic [7:0]  LVL_RESET    = 8'hFF;
  localparam logic [7:0]  LVL_MAX      = 8'hFF;
  localparam logic [7:0]  MUTE_FINE    = 8'h80;
  localparam logic [7:0]  MUTE_WIDE    = 8'h9A;
  localparam int          STEP_SAMPLES = 8;
  localparam logic [8:0]  HALF_DB_OCT  = 9'h00C;
  localparam logic [1:0]  DEEMPH_RATE_SEL_OFF     = 2'h0;
  localparam logic [1:0]  DEEMPH_RATE_SEL_48K     = 2'h1;
  localparam logic [1:0]  DEEMPH_RATE_SEL_44K1    = 2'h2;
  localparam logic [1:0]  DEEMPH_RATE_SEL_32K     = 2'h3;
  typedef enum logic [1:0] {
    DAZFC_DE_OFF, DAZFC_DE_48K, DAZFC_DE_44K1, DAZFC_DE_32K
  } dazfc_deemph_rate_sel_t;
endpackage
`default_nettype wire

// File: logic/dazfc_top.sv
// Per-channel soft attenuator with zero flag routing and config registers.
// Assumes fs_tick is a one-cycle pulse per sample period from the audio
// timing logic and zero detect levels come from logic on mclk.
`timescale 1ns/10ps
`default_nettype none
module dazfc_top
  import dazfc_pkg::*;
#(
  parameter int DW = 24
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              fs_tick,
  input  wire logic [1:0]        soft_mute_ctl,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [DW-1:0]     in_left,
  input  wire logic [DW-1:0]     in_right,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic      [DW-1:0]     out_left,
  output logic      [DW-1:0]     out_right,
  input  wire logic              zero_det_l,
  input  wire logic              zero_det_r,
  input  wire logic              analog_mute_out,
  output logic                   zero_flag_out1,
  output logic                   flag_pin_out,
  output logic                   deemph_en,
  output dazfc_deemph_rate_sel_t            deemph_rate_sel
);
  localparam logic [2:0] STEP_LAST = 3'(STEP_SAMPLES - 1);

  // Q15 gains for 0..11 half-dB steps; each further 12 steps halve it
  function automatic logic [15:0] frac_gain(input logic [3:0] r);
    case (r)
      4'h0: frac_gain = 16'h8000;
      4'h1: frac_gain = 16'h78D7;
      4'h2: frac_gain = 16'h7215;
      4'h3: frac_gain = 16'h6BB3;
      4'h4: frac_gain = 16'h65AD;
      4'h5: frac_gain = 16'h5FFD;
      4'h6: frac_gain = 16'h5A9E;
      4'h7: frac_gain = 16'h558C;
      4'h8: frac_gain = 16'h50C3;
      4'h9: frac_gain = 16'h4C3F;
      4'hA: frac_gain = 16'h47FB;
      default: frac_gain = 16'h43F4;
    endcase
  endfunction

  function automatic logic [7:0] mute_code(input logic mode);
    mute_code = mode ? MUTE_WIDE : MUTE_FINE; // [R9]
  endfunction

  function automatic logic [DW-1:0] scale(input logic [DW-1:0] s,
                                          input logic [7:0] code,
                                          input logic mode);
    logic [8:0]     att;
    logic [8:0]     oct;
    logic [15:0]    g;
    logic [DW+16:0] p;
    att = {1'b0, LVL_MAX - code};
    if (mode) att = {att[7:0], 1'b0}; // [R2] [R8]
    oct = att / HALF_DB_OCT;
    g = frac_gain(4'(att % HALF_DB_OCT)) >> oct; // [R1] [R8]
    p = (DW+17)'($signed(s) * $signed({1'b0, g}));
    if (code <= mute_code(mode)) scale = '0; // [R9]
    else scale = p[DW+14:15];
  endfunction

  // Registers
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] lvl_q [2];
  logic [7:0] lvl_d [2];
  logic [7:0] rd_q, rd_d;

  always_comb begin
    cfg_d = cfg_q;
    lvl_d = lvl_q;
    rd_d  = rd_q;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CFG:  cfg_d = reg_wdata & CFG_WMASK;
        ADDR_LVL1: lvl_d[0] = reg_wdata; // [R11]
        ADDR_LVL2: lvl_d[1] = reg_wdata; // [R11]
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CFG:  rd_d = cfg_q;
        ADDR_LVL1: rd_d = lvl_q[0];
        ADDR_LVL2: rd_d = lvl_q[1];
        default:   rd_d = '0; // Reserved gap and unmapped read as zero
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_q    <= CFG_RESET;
      lvl_q[0] <= LVL_RESET; // [R10]
      lvl_q[1] <= LVL_RESET; // [R10]
      rd_q     <= '0;
    end else begin
      cfg_q <= cfg_d;
      lvl_q <= lvl_d;
      rd_q  <= rd_d;
    end
  end
  assign reg_rdata = rd_q;

  logic mode;
  assign mode = cfg_q[BIT_MODE];

  // Ramp: applied codes move one code per step period toward target
  logic [2:0] tick_q, tick_d;
  logic [7:0] app_q [2];
  logic [7:0] app_d [2];
  logic [7:0] tgt   [2];

  always_comb begin
    tick_d = tick_q;
    app_d  = app_q;
    for (int c = 0; c < 2; c++) begin
      // Mute overrides the level; the level itself is kept untouched
      if (soft_mute_ctl[c] || lvl_q[c] < mute_code(mode))
        tgt[c] = mute_code(mode); // [R12]
      else
        tgt[c] = lvl_q[c];
    end
    if (fs_tick) begin
      tick_d = tick_q + 3'h1;
      if (tick_q == STEP_LAST) begin
        for (int c = 0; c < 2; c++) begin
          // Always steps from the applied code, never jumps
          if (app_q[c] < tgt[c]) app_d[c] = app_q[c] + 8'h01; // [R7] [R13]
          else if (app_q[c] > tgt[c]) app_d[c] = app_q[c] - 8'h01; // [R7]
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tick_q   <= '0;
      app_q[0] <= LVL_RESET; // [R10]
      app_q[1] <= LVL_RESET;
    end else begin
      tick_q <= tick_d;
      app_q  <= app_d;
    end
  end

  // Two-entry buffer ahead of the gain stage
  logic [2*DW-1:0] buf_q [2];
  logic [2*DW-1:0] buf_d [2];
  logic            wp_q, wp_d, rp_q, rp_d;
  logic [1:0]      cnt_q, cnt_d;
  logic            ov_q, ov_d;
  logic [DW-1:0]   ol_q, ol_d, or_q, or_d;
  logic            push, pop;

  assign in_ready = (cnt_q != 2'h2);
  assign push     = in_valid && in_ready;
  // Stall by the receiver holds the output, filling the buffer behind it
  assign pop      = (cnt_q != 2'h0) && (!ov_q || out_ready);

  always_comb begin
    buf_d = buf_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    ov_d  = ov_q;
    ol_d  = ol_q;
    or_d  = or_q;
    if (push) begin
      buf_d[wp_q] = {in_left, in_right};
      wp_d = ~wp_q;
    end
    if (out_ready) ov_d = 1'b0;
    if (pop) begin
      rp_d = ~rp_q;
      ov_d = 1'b1;
      ol_d = scale(buf_q[rp_q][2*DW-1:DW], app_q[0], mode);
      or_d = scale(buf_q[rp_q][DW-1:0], app_q[1], mode);
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= '0;
      ov_q     <= 1'b0;
      ol_q     <= '0;
      or_q     <= '0;
    end else begin
      buf_q <= buf_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      ov_q  <= ov_d;
      ol_q  <= ol_d;
      or_q  <= or_d;
    end
  end
  assign out_valid = ov_q;
  assign out_left  = ol_q;
  assign out_right = or_q;

  // Flag routing, registered so the pins never glitch
  logic z1_q, z1_d, pin_q, pin_d;
  logic f1, f2;

  always_comb begin
    if (cfg_q[BIT_COMBO]) begin
      f1 = zero_det_l | zero_det_r; // [R5]
      f2 = zero_det_l & zero_det_r; // [R5]
    end else begin
      f1 = zero_det_l; // [R5]
      f2 = zero_det_r;
    end
    z1_d  = f1 ^ cfg_q[BIT_POL]; // [R6]
    // Analog mute keeps its own sense; polarity applies to zero flags only
    pin_d = cfg_q[BIT_PINSEL] ? analog_mute_out
                              : (f2 ^ cfg_q[BIT_POL]); // [R4] [R6]
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      z1_q  <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      z1_q  <= z1_d;
      pin_q <= pin_d;
    end
  end
  assign zero_flag_out1 = z1_q;
  assign flag_pin_out   = pin_q;

  // De-emphasis selection to the filter
  always_comb begin
    case (cfg_q[BIT_DEEMPH_RATE_SEL_HI:BIT_DEEMPH_RATE_SEL_LO])
      DEEMPH_RATE_SEL_48K:  deemph_rate_sel = DAZFC_DE_48K; // [R3]
      DEEMPH_RATE_SEL_44K1: deemph_rate_sel = DAZFC_DE_44K1; // [R3]
      DEEMPH_RATE_SEL_32K:  deemph_rate_sel = DAZFC_DE_32K; // [R3]
      default:   deemph_rate_sel = DAZFC_DE_OFF; // [R3]
    endcase
  end
  assign deemph_en = (cfg_q[BIT_DEEMPH_RATE_SEL_HI:BIT_DEEMPH_RATE_SEL_LO] != DEEMPH_RATE_SEL_OFF); // [R3]
endmodule
`default_nettype wire

// File: sim/dazfc_sink.sv
// Downstream sink for the output stream of dazfc_top.
// Assumes the bench drives stall on the clock edge.
`timescale 1ns/10ps
`default_nettype none
module dazfc_sink (
  input  wire logic resetn,
  input  wire logic stall,
  output logic      out_ready
);
  // Not ready in reset, so no word is taken while the block clears
  assign out_ready = resetn & ~stall;
endmodule
`default_nettype wire

// File: sim/dazfc_sva.sv
// Checker for dazfc_top: flag routing, config readback, output stream.
// Bound to the top module and sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module dazfc_sva
  import dazfc_pkg::*;
#(
  parameter int DW = 24
) (
  input wire logic              mclk,
  input wire logic              resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire logic              in_valid,
  input wire logic              in_ready,
  input wire logic              out_valid,
  input wire logic              out_ready,
  input wire logic [DW-1:0]     out_left,
  input wire logic              zero_det_l,
  input wire logic              zero_det_r,
  input wire logic              analog_mute_out,
  input wire logic              zero_flag_out1,
  input wire logic              flag_pin_out,
  input wire logic              deemph_en,
  input wire dazfc_deemph_rate_sel_t       deemph_rate_sel
);
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic       f1;
  logic       f2;
  // Mirror of the config byte, so flag routing can be predicted
  always_comb begin
    cfg_d = cfg_q;
    if (reg_wr && reg_addr == ADDR_CFG) cfg_d = reg_wdata & CFG_WMASK;
    f1 = cfg_q[BIT_COMBO] ? zero_det_l | zero_det_r : zero_det_l;
    f2 = cfg_q[BIT_COMBO] ? zero_det_l & zero_det_r : zero_det_r;
    f1 = f1 ^ cfg_q[BIT_POL];
    f2 = cfg_q[BIT_PINSEL] ? analog_mute_out : f2 ^ cfg_q[BIT_POL];
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) cfg_q <= 8'h00;
    else cfg_q <= cfg_d;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_FLAG1: assert property ($past(resetn) |-> zero_flag_out1 == $past(f1))
    else $error("zero flag 1 wrong");
  AST_FLAGPIN: assert property ($past(resetn) |-> flag_pin_out == $past(f2))
    else $error("shared flag pin wrong");
  AST_DEEMPH: assert property (deemph_rate_sel == cfg_q[5:4] && deemph_en == (cfg_q[5:4] != 2'h0))
    else $error("de-emphasis select wrong");
  AST_CFG_RD: assert property (reg_rd && reg_addr == ADDR_CFG |=> reg_rdata == $past(cfg_q))
    else $error("config readback wrong");
  AST_RSVD: assert property (reg_rd && reg_addr == ADDR_RSVD |=> reg_rdata == 8'h00)
    else $error("reserved read not zero");
  AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  AST_OUT_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_left))
    else $error("stalled output word moved");
  // An empty buffer needs one edge to store the word and one to present it
  AST_OUT_PUSH: assert property (in_valid && in_ready && !out_valid |-> ##[1:2] out_valid)
    else $error("pushed word not presented");
  cover property (reg_wr && reg_addr == ADDR_CFG);
  cover property (out_valid && !out_ready);
  cover property (!in_ready);
endmodule
bind dazfc_top dazfc_sva #(.DW(DW)) u_sva (.mclk, .resetn, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .in_valid, .in_ready,
  .out_valid, .out_ready, .out_left, .zero_det_l, .zero_det_r,
  .analog_mute_out, .zero_flag_out1, .flag_pin_out, .deemph_en,
  .deemph_rate_sel);
`default_nettype wire

// File: sim/tb_dazfc_top.sv
// Bench for dazfc_top: flag table, registers, buffer, attenuation ramp.
// Assumes dazfc_sink and the bound checker are compiled with it.
`timescale 1ns/10ps
`default_nettype none
module tb_dazfc_top;
  import dazfc_pkg::*;
  logic mclk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, fs_tick = 0;
  logic in_valid = 0, zero_det_l = 0, zero_det_r = 0, analog_mute_out = 0;
  logic stall = 0, in_ready, out_valid, out_ready;
  logic zero_flag_out1, flag_pin_out, deemph_en;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [1:0] soft_mute_ctl = 2'h0;
  logic [23:0] in_left = 0, in_right = 0, out_left, out_right, ol, orr;
  dazfc_deemph_rate_sel_t deemph_rate_sel;
  int n_mismatch = 0, num_checks = 0, k;
  // Rows: {cfg, det left, det right, analog mute, flag1, pin}
  logic [12:0] rows [11] = '{13'h0012, 13'h0009, 13'h0052, 13'h005B,
    13'h0031, 13'h010D, 13'h0108, 13'h0127, 13'h1FE2, 13'h0280, 13'h0400};
  always #25 mclk = ~mclk;
  always @(posedge mclk) fs_tick <= ~fs_tick;
  dazfc_top #(.DW(24)) DUT (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .fs_tick, .soft_mute_ctl, .in_valid, .in_ready,
    .in_left, .in_right, .out_valid, .out_ready, .out_left, .out_right,
    .zero_det_l, .zero_det_r, .analog_mute_out, .zero_flag_out1,
    .flag_pin_out, .deemph_en, .deemph_rate_sel);
  dazfc_sink u_sink (.resetn, .stall, .out_ready);
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string s, logic [23:0] e, logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic chk_nz(string s, logic [23:0] g);
    num_checks++;
    if ((|g) !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %s exp nonzero got %h", s, g);
    end
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge mclk);
    reg_wr <= 0;
    @(posedge mclk);
  endtask
  task automatic rd(string s, logic [6:0] a, logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge mclk);
    reg_rd <= 0;
    @(posedge mclk);
    #1 chk(s, e, reg_rdata);
  endtask
  // One word through the stream; bounded wait for the output
  task automatic xfer(logic [23:0] d);
    in_left <= d;
    in_right <= d;
    in_valid <= 1;
    @(posedge mclk);
    in_valid <= 0;
    k = 0;
    #1 while (out_valid !== 1 && k < 50) begin
      @(posedge mclk);
      #1 k++;
    end
    if (k >= 50) begin
      n_mismatch++;
      summarize();
    end
    ol = out_left;
    orr = out_right;
    @(posedge mclk);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1;
    @(posedge mclk);
    rd("cfg", ADDR_CFG, 8'h00);
    rd("lvl1", ADDR_LVL1, 8'hFF);
    rd("lvl2", ADDR_LVL2, 8'hFF);
    wr(ADDR_RSVD, 8'h5A);
    rd("rsvd", ADDR_RSVD, 8'h00);
    rd("unmapped", 7'h7F, 8'h00);
    foreach (rows[i]) begin
      {zero_det_l, zero_det_r, analog_mute_out} <= rows[i][4:2];
      wr(ADDR_CFG, rows[i][12:5]);
      rd("cfg", ADDR_CFG, rows[i][12:5] & CFG_WMASK);
      chk("flag1", rows[i][1], zero_flag_out1);
      chk("pin", rows[i][0], flag_pin_out);
      chk("deemph_rate_sel", rows[i][10:9], deemph_rate_sel);
      chk("deemph_rate_sel_en", |rows[i][10:9], deemph_en);
    end
    @(posedge mclk);
    stall <= 1;
    in_left <= 24'h40_0000;
    in_valid <= 1;
    @(posedge mclk);
    in_left <= 0;
    @(posedge mclk);
    in_left <= 24'h40_0000;
    // First word moves to the output, so the third fills the buffer
    @(posedge mclk);
    #1 chk("full", 0, in_ready);
    @(posedge mclk);
    in_valid <= 0;
    stall <= 0;
    #1 chk("word1", 24'h40_0000, out_left);
    chk("refused", 0, in_ready);
    @(posedge mclk);
    #1 chk("word2", 0, out_left);
    @(posedge mclk);
    #1 chk("word3", 24'h40_0000, out_left);
    @(posedge mclk);
    #1 chk("drained", 0, out_valid);
    soft_mute_ctl <= 2'h2;
    wr(ADDR_LVL1, 8'h80);
    rd("lvl1", ADDR_LVL1, 8'h80);
    rd("lvl2", ADDR_LVL2, 8'hFF);
    // Ramp of 127 steps needs 1009..1016 ticks; sample either side
    repeat (1985) @(posedge mclk);
    xfer(24'h40_0000);
    chk_nz("left ramp", ol);
    chk_nz("right ramp", orr);
    repeat (60) @(posedge mclk);
    xfer(24'h40_0000);
    chk("left mute", 0, ol);
    chk("right mute", 0, orr);
    soft_mute_ctl <= 2'h0;
    repeat (40) @(posedge mclk);
    xfer(24'h40_0000);
    chk("left held", 0, ol);
    chk_nz("right back", orr);
    // Wide mode reinterprets applied codes: both are at or below 154
    wr(ADDR_CFG, 8'h80);
    xfer(24'h40_0000);
    chk("left wide", 0, ol);
    chk("right wide", 0, orr);
    resetn <= 0;
    repeat (3) @(posedge mclk);
    resetn <= 1;
    @(posedge mclk);
    rd("cfg rst", ADDR_CFG, 8'h00);
    rd("lvl1 rst", ADDR_LVL1, 8'hFF);
    xfer(24'h40_0000);
    chk("left 0 dB", 24'h40_0000, ol);
    chk("right 0 dB", 24'h40_0000, orr);
    summarize();
  end
endmodule
`default_nettype wire
